// >>> src/iabr_pkg.sv
package iabr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 200;
  localparam int AZ_FLOAT_NS  = 1000;
  // least time, so round up to whole cycles
  localparam int AZ_FLOAT_CYC = (AZ_FLOAT_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // result layout, bipolar_offset_code
  // ----------------------------------------------------------------
  localparam int          RESULT_W = 22;
  localparam int          FRAC_W   = 21;
  localparam logic [21:0] CODE_BOT = 22'h000000;
  localparam logic [21:0] CODE_MID = 22'h200000;
  localparam logic [21:0] CODE_TOP = 22'h3fffff;
  localparam int          MSB_POS  = 16;
  localparam int          MSB_W    = 6;
  localparam int          MID_POS  = 8;
  localparam int          LSB_POS  = 0;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_RESULT   = 8'h08;
  localparam logic [7:0] ADDR_TPOS     = 8'h0c;
  localparam logic [7:0] ADDR_TNEG     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h1c;
  localparam int         CTRL_AZ_BIT   = 0;
  localparam int         IRQ_CONV      = 0;
  localparam int         IRQ_READ      = 1;
  localparam int         IRQ_AZ        = 2;
  localparam int         IRQ_W         = 3;
  localparam logic [2:0] IRQ_EN_RST    = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_CONV     = 3'h1,
    ST_CALC     = 3'h3,
    ST_MSB      = 3'h2,
    ST_MID      = 3'h6,
    ST_AZ_FLOAT = 3'h4,
    ST_AZ_INT   = 3'h5
  } iabr_state_t;

  typedef struct packed {
    logic high;
    logic low;
  } iabr_phase_t;

  typedef struct packed {
    logic convert_n;
    logic output_enable_n;
    logic auto_zero_n;
    logic integ_trip;
  } iabr_pins_t;

  localparam iabr_pins_t  PINS_RST  = 4'he;
  localparam iabr_phase_t PH_BUSY   = 2'h0;
  localparam iabr_phase_t PH_MSB    = 2'h1;
  localparam iabr_phase_t PH_MID    = 2'h2;
  localparam iabr_phase_t PH_READY  = 2'h3;

endpackage : iabr_pkg

// >>> src/iabr_divider.sv
`timescale 1ns/1ps
module iabr_divider #(
  parameter int NW = 46,
  parameter int DW = 25
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // request
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  // answer
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quo
);

  localparam int CW = $clog2(NW + 1);

  logic [NW-1:0] quo_reg, quo_next;
  logic [DW:0]   rem_reg, rem_next;
  logic [DW-1:0] den_reg, den_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          done_reg, done_next;
  logic [DW:0]   shifted;
  logic [DW:0]   trial;

  // ----------------------------------------------------------------
  // restoring division, one quotient bit per cycle
  // ----------------------------------------------------------------
  always_comb begin
    quo_next  = quo_reg;
    rem_next  = rem_reg;
    den_next  = den_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    shifted   = {rem_reg[DW-1:0], quo_reg[NW-1]};
    trial     = shifted - {1'b0, den_reg};
    if (start) begin
      quo_next = num;
      rem_next = '0;
      den_next = den;
      cnt_next = CW'(NW);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
      if (!trial[DW]) begin
        rem_next = trial;
        quo_next = {quo_reg[NW-2:0], 1'b1};
      end else begin
        rem_next = shifted;
        quo_next = {quo_reg[NW-2:0], 1'b0};
      end
      done_next = (cnt_reg == CW'(1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quo_reg  <= '0;
      rem_reg  <= '0;
      den_reg  <= '0;
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      quo_reg  <= quo_next;
      rem_reg  <= rem_next;
      den_reg  <= den_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;
  assign quo  = quo_reg;

endmodule : iabr_divider

// >>> src/iabr_core.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module iabr_core #(
  parameter int CNT_W       = 24,
  parameter int SLOPE_EDGES = 8
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // converter pins
  input  wire logic        convert_n,
  input  wire logic        output_enable_n,
  input  wire logic        auto_zero_n,
  output logic [7:0]       data_o,
  output logic             data_oe,
  output iabr_pkg::iabr_phase_t phase_flags,
  output logic             phase_flags_oe,
  // analog front end
  input  wire logic        integ_trip,
  output logic             ref_positive,
  output logic             inputs_shorted,
  // interrupt
  output logic             irq
);

  localparam int EW = $clog2(SLOPE_EDGES + 1);
  localparam int SW = CNT_W + 2;
  localparam int NW = CNT_W + 1 + iabr_pkg::FRAC_W;
  localparam int TW = $clog2(iabr_pkg::AZ_FLOAT_CYC + 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  iabr_pkg::iabr_pins_t pins_s1_reg, pins_s2_reg, pins_s3_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1_reg <= iabr_pkg::PINS_RST;
      pins_s2_reg <= iabr_pkg::PINS_RST;
      pins_s3_reg <= iabr_pkg::PINS_RST;
    end else begin
      pins_s1_reg <= {convert_n, output_enable_n, auto_zero_n, integ_trip};
      pins_s2_reg <= pins_s1_reg;
      pins_s3_reg <= pins_s2_reg;
    end
  end

  logic conv_fall, trip_rise, sw_az, az_go;
  assign conv_fall = pins_s3_reg.convert_n & ~pins_s2_reg.convert_n;
  assign trip_rise = ~pins_s3_reg.integ_trip & pins_s2_reg.integ_trip;
  assign az_go     = ~pins_s2_reg.auto_zero_n | sw_az;

  // ----------------------------------------------------------------
  // sequencer and slope counters
  // ----------------------------------------------------------------
  iabr_pkg::iabr_state_t state_reg, state_next;
  iabr_pkg::iabr_phase_t flags_reg, flags_next;
  logic [CNT_W-1:0]    tp_reg, tp_next, tm_reg, tm_next;
  logic [EW-1:0]       edges_reg, edges_next;
  logic                armed_reg, armed_next, slope_reg, slope_next;
  logic [TW-1:0]       tmr_reg, tmr_next;
  logic signed [SW-1:0] offs_reg, offs_next, tdiff;
  logic [SW-1:0]       tmag;
  logic [7:0]          byte_reg, byte_next;
  logic [21:0]         result_reg, result_next, code;
  logic                neg_reg, neg_next, flags_oe_reg, flags_oe_next;
  logic                div_start, div_done, div_busy, integ_done;
  logic [NW-1:0]       div_q;
  logic [iabr_pkg::IRQ_W-1:0] events;

  function automatic logic in_integ(input iabr_pkg::iabr_state_t s);
    return (s == iabr_pkg::ST_CONV) || (s == iabr_pkg::ST_AZ_INT);
  endfunction : in_integ

  function automatic logic in_az(input iabr_pkg::iabr_state_t s);
    return (s == iabr_pkg::ST_AZ_FLOAT) || (s == iabr_pkg::ST_AZ_INT);
  endfunction : in_az

  // offset captured in auto-zero is removed from every conversion
  assign tdiff = SW'(signed'({2'h0, tp_reg})) - SW'(signed'({2'h0, tm_reg}))
               - offs_reg;
  assign tmag  = tdiff[SW-1] ? SW'(-tdiff) : SW'(tdiff);
  assign integ_done = in_integ(state_reg) && (edges_reg == EW'(SLOPE_EDGES));

  // saturate the scaled ratio around mid scale
  always_comb begin
    if (div_q[NW-1:iabr_pkg::FRAC_W] != '0)
      code = neg_reg ? iabr_pkg::CODE_BOT : iabr_pkg::CODE_TOP;
    else if (neg_reg)
      code = iabr_pkg::CODE_MID - {1'b0, div_q[iabr_pkg::FRAC_W-1:0]};
    else
      code = iabr_pkg::CODE_MID + {1'b0, div_q[iabr_pkg::FRAC_W-1:0]};
  end

  always_comb begin
    state_next  = state_reg;
    tp_next     = tp_reg;
    tm_next     = tm_reg;
    edges_next  = edges_reg;
    armed_next  = armed_reg;
    slope_next  = slope_reg;
    tmr_next    = tmr_reg;
    offs_next   = offs_reg;
    byte_next   = byte_reg;
    result_next = result_reg;
    neg_next    = neg_reg;
    div_start   = 1'b0;
    events      = '0;
    // slope timing; partial first slope dropped, counts frozen when done
    if (in_integ(state_reg) && !integ_done) begin
      if (armed_reg && slope_reg)
        tp_next = tp_reg + 1'b1;
      else if (armed_reg)
        tm_next = tm_reg + 1'b1;
      if (trip_rise) begin
        slope_next = ~slope_reg;
        armed_next = 1'b1;
        if (armed_reg)
          edges_next = edges_reg + 1'b1;
      end
    end
    if (az_go) begin
      state_next = iabr_pkg::ST_AZ_FLOAT;
      tmr_next   = '0;
    end else begin
      unique case (state_reg)
        iabr_pkg::ST_AZ_FLOAT: begin
          tmr_next = tmr_reg + 1'b1;
          if (tmr_reg == TW'(iabr_pkg::AZ_FLOAT_CYC - 1))
            state_next = iabr_pkg::ST_AZ_INT;
        end
        iabr_pkg::ST_AZ_INT: begin
          if (integ_done) begin
            offs_next  = tdiff + offs_reg;
            state_next = iabr_pkg::ST_IDLE;
            events[iabr_pkg::IRQ_AZ] = 1'b1;
          end
        end
        iabr_pkg::ST_IDLE: begin
          if (conv_fall)
            state_next = iabr_pkg::ST_CONV;
        end
        iabr_pkg::ST_CONV: begin
          // further convert edges fall through untouched
          if (integ_done) begin
            div_start  = 1'b1;
            neg_next   = tdiff[SW-1];
            state_next = iabr_pkg::ST_CALC;
          end
        end
        iabr_pkg::ST_CALC: begin
          if (div_done) begin
            result_next = code;
            byte_next   = {2'h0, code[iabr_pkg::MSB_POS +: iabr_pkg::MSB_W]};
            state_next  = iabr_pkg::ST_MSB;
            events[iabr_pkg::IRQ_CONV] = 1'b1;
          end
        end
        iabr_pkg::ST_MSB: begin
          if (conv_fall) begin
            byte_next  = result_reg[iabr_pkg::MID_POS +: 8];
            state_next = iabr_pkg::ST_MID;
          end
        end
        iabr_pkg::ST_MID: begin
          if (conv_fall) begin
            byte_next  = result_reg[iabr_pkg::LSB_POS +: 8];
            state_next = iabr_pkg::ST_IDLE;
            events[iabr_pkg::IRQ_READ] = 1'b1;
          end
        end
        default: state_next = iabr_pkg::ST_AZ_FLOAT;
      endcase
    end
    // fresh counters on entry to any integration phase
    if (in_integ(state_next) && !in_integ(state_reg)) begin
      tp_next    = '0;
      tm_next    = '0;
      edges_next = '0;
      armed_next = 1'b0;
    end
  end

  // flags follow the state one cycle late, so a byte is always in the
  // buffer before the flags announce it
  always_comb begin
    flags_oe_next = (state_reg != iabr_pkg::ST_AZ_FLOAT);
    unique case (state_reg)
      iabr_pkg::ST_IDLE: flags_next = iabr_pkg::PH_READY;
      iabr_pkg::ST_MSB:  flags_next = iabr_pkg::PH_MSB;
      iabr_pkg::ST_MID:  flags_next = iabr_pkg::PH_MID;
      default:           flags_next = iabr_pkg::PH_BUSY;
    endcase
  end

  // power-up leaves the sequencer in auto-zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= iabr_pkg::ST_AZ_FLOAT;
      flags_reg    <= iabr_pkg::PH_BUSY;
      flags_oe_reg <= 1'b0;
      tp_reg       <= '0;
      tm_reg       <= '0;
      edges_reg    <= '0;
      armed_reg    <= 1'b0;
      slope_reg    <= 1'b1;
      tmr_reg      <= '0;
      offs_reg     <= '0;
      byte_reg     <= 8'h00;
      result_reg   <= iabr_pkg::CODE_BOT;
      neg_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      flags_reg    <= flags_next;
      flags_oe_reg <= flags_oe_next;
      tp_reg       <= tp_next;
      tm_reg       <= tm_next;
      edges_reg    <= edges_next;
      armed_reg    <= armed_next;
      slope_reg    <= slope_next;
      tmr_reg      <= tmr_next;
      offs_reg     <= offs_next;
      byte_reg     <= byte_next;
      result_reg   <= result_next;
      neg_reg      <= neg_next;
    end
  end

  iabr_divider #(.NW(NW), .DW(CNT_W + 1)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (div_start),
    .num     ({tmag[CNT_W:0], iabr_pkg::FRAC_W'(0)}),
    .den     ({1'b0, tp_reg} + {1'b0, tm_reg}),
    .busy    (div_busy),
    .done    (div_done),
    .quo     (div_q)
  );

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  logic data_oe_reg, shorted_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_oe_reg <= 1'b0;
      shorted_reg <= 1'b1;
    end else begin
      data_oe_reg <= ~pins_s2_reg.output_enable_n;
      shorted_reg <= in_az(state_next);
    end
  end

  assign data_o         = byte_reg;
  assign data_oe        = data_oe_reg;
  assign phase_flags    = flags_reg;
  assign phase_flags_oe = flags_oe_reg;
  assign ref_positive   = slope_reg;
  assign inputs_shorted = shorted_reg;

  // ----------------------------------------------------------------
  // apb slave and interrupts
  // ----------------------------------------------------------------
  logic [iabr_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [iabr_pkg::IRQ_W-1:0] irq_en_reg, irq_en_next, irq_clr;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr, mapped;

  assign wr    = psel & penable & pwrite;
  assign sw_az = wr && (paddr == iabr_pkg::ADDR_CTRL)
              && pwdata[iabr_pkg::CTRL_AZ_BIT];

  always_comb begin
    mapped     = 1'b1;
    rdata_next = rdata_reg;
    unique case (paddr)
      iabr_pkg::ADDR_CTRL:     rdata_next = 32'h0;
      iabr_pkg::ADDR_STATUS:   rdata_next = {25'h0, div_busy, flags_oe_reg,
                                  flags_reg, 3'(state_reg)};
      iabr_pkg::ADDR_RESULT:   rdata_next = {10'h0, result_reg};
      iabr_pkg::ADDR_TPOS:     rdata_next = 32'(tp_reg);
      iabr_pkg::ADDR_TNEG:     rdata_next = 32'(tm_reg);
      iabr_pkg::ADDR_IRQ_STAT: rdata_next = 32'(irq_stat_reg);
      iabr_pkg::ADDR_IRQ_EN:   rdata_next = 32'(irq_en_reg);
      iabr_pkg::ADDR_IRQ_CLR:  rdata_next = 32'h0;
      default: mapped = 1'b0;
    endcase
    if (!(psel && !penable && !pwrite))
      rdata_next = rdata_reg;
    irq_clr = (wr && paddr == iabr_pkg::ADDR_IRQ_CLR)
            ? pwdata[iabr_pkg::IRQ_W-1:0] : '0;
    irq_en_next = (wr && paddr == iabr_pkg::ADDR_IRQ_EN)
                ? pwdata[iabr_pkg::IRQ_W-1:0] : irq_en_reg;
    // a new event outweighs a clear in the same cycle
    irq_stat_next = (irq_stat_reg & ~irq_clr) | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg    <= 32'h0;
      irq_stat_reg <= '0;
      irq_en_reg   <= iabr_pkg::IRQ_EN_RST;
    end else begin
      rdata_reg    <= rdata_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg   <= irq_en_next;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign irq     = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  conv_start_a: assert property (
    state_reg == iabr_pkg::ST_IDLE && conv_fall && !az_go
    |=> state_reg == iabr_pkg::ST_CONV ##1 flags_reg == iabr_pkg::PH_BUSY)
    else $error("convert edge in ready did not start");
  flags_low_a: assert property (
    state_reg == iabr_pkg::ST_CONV || state_reg == iabr_pkg::ST_CALC
    |=> flags_reg == iabr_pkg::PH_BUSY && flags_oe_reg)
    else $error("flags not low while converting");
  msb_first_a: assert property (
    state_reg == iabr_pkg::ST_CALC && div_done && !az_go
    |=> byte_reg == {2'h0, result_reg[21:16]} && !flags_reg.low
    ##1 flags_reg == iabr_pkg::PH_MSB)
    else $error("msb byte not ahead of low flag");
  mid_byte_a: assert property (
    state_reg == iabr_pkg::ST_MSB && conv_fall && !az_go
    |=> byte_reg == result_reg[15:8] ##1 flags_reg == iabr_pkg::PH_MID)
    else $error("middle byte step wrong");
  lsb_ready_a: assert property (
    state_reg == iabr_pkg::ST_MID && conv_fall && !az_go
    |=> byte_reg == result_reg[7:0] ##1 flags_reg == iabr_pkg::PH_READY)
    else $error("lsb step wrong");
  data_drive_a: assert property (
    output_enable_n [*3] |=> !data_oe)
    else $error("data port driven with enable high");
  az_short_a: assert property (
    !auto_zero_n [*3] |=> inputs_shorted
    && state_reg == iabr_pkg::ST_AZ_FLOAT)
    else $error("auto-zero did not short inputs");
  az_float_a: assert property (
    state_reg == iabr_pkg::ST_AZ_FLOAT |=> !flags_oe_reg)
    else $error("flags driven during auto-zero float");
  mid_code_a: assert property (
    state_reg == iabr_pkg::ST_CALC && div_done && div_q == '0 && !az_go
    |=> result_reg == iabr_pkg::CODE_MID)
    else $error("zero ratio not mid code");
  conv_hold_a: assert property (
    state_reg == iabr_pkg::ST_CONV && conv_fall && !az_go && !integ_done
    |=> state_reg == iabr_pkg::ST_CONV && $stable(result_reg))
    else $error("convert edge disturbed conversion");

  conv_done_c: cover property (state_reg == iabr_pkg::ST_CALC ##1
    state_reg == iabr_pkg::ST_MSB);
  readout_c: cover property (state_reg == iabr_pkg::ST_MID ##1
    state_reg == iabr_pkg::ST_IDLE);
  az_done_c: cover property (state_reg == iabr_pkg::ST_AZ_INT ##1
    state_reg == iabr_pkg::ST_IDLE);

endmodule : iabr_core

// >>> bench/iabr_front_model.sv
`timescale 1ns/1ps
module iabr_front_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // slope control from the core
  input  wire logic        ref_positive,
  input  wire logic        inputs_shorted,
  // slope lengths in cycles
  input  wire logic [23:0] tp_cyc,
  input  wire logic [23:0] tm_cyc,
  // schmitt trigger
  output logic             integ_trip
);
  // ----------------------------------------------------------------
  // integrator
  // ----------------------------------------------------------------
  logic [23:0] cnt_reg;
  logic [23:0] len;
  logic        last_reg;

  // shorted inputs ramp alike both ways, so the offset reads zero
  assign len = inputs_shorted ? 24'h14 : (ref_positive ? tp_cyc : tm_cyc);
  assign integ_trip = (cnt_reg >= len) && (cnt_reg < len + 24'h3);

  // keeps firing if the core never reverses, like a stuck ramp would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 24'h0;
      last_reg <= 1'h1;
    end else if (ref_positive != last_reg) begin
      last_reg <= ref_positive;
      cnt_reg  <= 24'h0;
    end else if (cnt_reg >= len + 24'h5) begin
      cnt_reg <= 24'h0;
    end else begin
      cnt_reg <= cnt_reg + 24'h1;
    end
  end
endmodule : iabr_front_model

// >>> bench/tb_iabr_core.sv
`timescale 1ns/1ps
module tb_iabr_core;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                  pclk, presetn, psel, penable, pwrite;
  logic                  pready, pslverr, err, irq;
  logic [7:0]            paddr, data_o;
  logic [31:0]           pwdata, prdata, rd, tp, tm;
  logic                  convert_n, output_enable_n, auto_zero_n;
  logic                  integ_trip, data_oe, phase_flags_oe;
  logic                  ref_positive, inputs_shorted;
  iabr_pkg::iabr_phase_t phase_flags;
  logic [23:0]           tp_cyc, tm_cyc;
  logic [47:0]           q, code;
  int                    fail_count, checks;

  iabr_core #(.SLOPE_EDGES(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convert_n(convert_n),
    .output_enable_n(output_enable_n), .auto_zero_n(auto_zero_n),
    .data_o(data_o), .data_oe(data_oe), .phase_flags(phase_flags),
    .phase_flags_oe(phase_flags_oe), .integ_trip(integ_trip),
    .ref_positive(ref_positive), .inputs_shorted(inputs_shorted),
    .irq(irq));

  iabr_front_model u_fe (
    .pclk(pclk), .presetn(presetn), .ref_positive(ref_positive),
    .inputs_shorted(inputs_shorted), .tp_cyc(tp_cyc), .tm_cyc(tm_cyc),
    .integ_trip(integ_trip));

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task give_verdict;
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // released a cycle before the next setup, never in the same step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task pulse;
    convert_n <= 1'h0;
    repeat (4) @(posedge pclk);
    convert_n <= 1'h1;
    repeat (4) @(posedge pclk);
  endtask : pulse

  task wait_flags(input iabr_pkg::iabr_phase_t f, input int n);
    for (int i = 0; i < n && phase_flags !== f; i++) @(posedge pclk);
    chk("phase_flags", phase_flags, f);
  endtask : wait_flags

  task conv;
    pulse();
    wait_flags(iabr_pkg::PH_BUSY, 20);
    output_enable_n <= 1'h0;
    pulse();
    chk("flags ignore", phase_flags, iabr_pkg::PH_BUSY);
    wait_flags(iabr_pkg::PH_MSB, 3000);
    chk("data_oe on", data_oe, 1'h1);
    apb(1'h0, iabr_pkg::ADDR_TPOS, 32'h0);
    tp = rd;
    apb(1'h0, iabr_pkg::ADDR_TNEG, 32'h0);
    tm = rd;
    q = ({16'h0, (tp > tm) ? tp - tm : tm - tp} << 21) / (tp + tm);
    code = (tp >= tm) ? 48'h200000 + q : 48'h200000 - q;
    chk("msb byte", data_o, {2'h0, code[21:16]});
    apb(1'h0, iabr_pkg::ADDR_RESULT, 32'h0);
    chk("result", rd[21:0], code);
    chk("msb value", data_o, {2'h0, code[21:16]});
    output_enable_n <= 1'h1;
    repeat (4) @(posedge pclk);
    chk("data_oe off", data_oe, 1'h0);
    output_enable_n <= 1'h0;
    pulse();
    wait_flags(iabr_pkg::PH_MID, 20);
    chk("mid byte", data_o, code[15:8]);
    pulse();
    wait_flags(iabr_pkg::PH_READY, 20);
    chk("lsb byte", data_o, code[7:0]);
  endtask : conv

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {convert_n, output_enable_n, auto_zero_n} = 3'h7;
    tp_cyc = 24'h14;
    tm_cyc = 24'h14;
    code = 48'h200000;
    fail_count = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    chk("flags_oe reset", phase_flags_oe, 1'h0);
    chk("shorted reset", inputs_shorted, 1'h1);
    chk("ref reset", ref_positive, 1'h1);
    presetn <= 1'h1;
    repeat (20) @(posedge pclk);
    chk("flags float", phase_flags_oe, 1'h0);
    for (int i = 0; i < 400 && phase_flags_oe !== 1'h1; i++) @(posedge pclk);
    chk("flags az low", phase_flags, iabr_pkg::PH_BUSY);
    wait_flags(iabr_pkg::PH_READY, 2000);
    chk("shorted off", inputs_shorted, 1'h0);
    apb(1'h0, iabr_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd[6:0], {2'h1, iabr_pkg::PH_READY,
        3'(iabr_pkg::ST_IDLE)});
    conv();
    // interrupts: all three events seen so far
    apb(1'h1, iabr_pkg::ADDR_IRQ_EN, 32'h2);
    chk("irq on", irq, 1'h1);
    apb(1'h1, iabr_pkg::ADDR_IRQ_CLR, 32'h2);
    chk("irq cleared", irq, 1'h0);
    apb(1'h0, iabr_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("irq stat", rd[2:0], 3'h5);
    apb(1'h1, iabr_pkg::ADDR_IRQ_CLR, 32'h7);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped", err, 1'h1);
    tp_cyc <= 24'h1e;
    tm_cyc <= 24'ha;
    conv();
    pulse();
    wait_flags(iabr_pkg::PH_BUSY, 20);
    auto_zero_n <= 1'h0;
    repeat (8) @(posedge pclk);
    chk("az float", phase_flags_oe, 1'h0);
    chk("az short", inputs_shorted, 1'h1);
    auto_zero_n <= 1'h1;
    for (int i = 0; i < 400 && phase_flags_oe !== 1'h1; i++) @(posedge pclk);
    chk("az low", phase_flags, iabr_pkg::PH_BUSY);
    wait_flags(iabr_pkg::PH_READY, 2000);
    apb(1'h0, iabr_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("az done", rd[2], 1'h1);
    apb(1'h1, iabr_pkg::ADDR_CTRL, 32'h1);
    repeat (8) @(posedge pclk);
    chk("ctrl az", phase_flags_oe, 1'h0);
    wait_flags(iabr_pkg::PH_READY, 3000);
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
endmodule : tb_iabr_core
